// ### hw/step_pkg.sv
// Shared constants for the step/direction power stage control and indexer.
// Assumes a single 250 MHz clock on both ends.
package step_pkg;
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned IDLE_MS        = 40;
  localparam int unsigned IDLE_CYCLES    = IDLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned MAX_STEP_KHZ   = 500;
  localparam int unsigned MIN_PERIOD_CYC = (CLK_MHZ * 1000) / MAX_STEP_KHZ;
  localparam int unsigned DIR_HOLD_NS    = 1000;
  localparam int unsigned DIR_HOLD_CYC   = (DIR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BOOST_PCT      = 30;
  localparam int unsigned RING_W         = 7;
  localparam logic [3:0]  RES_RESET      = 4'h0;
  // Phase current command codes
  typedef enum logic [1:0] {
    CUR_OFF,
    CUR_STOP,
    CUR_RUN
  } cur_mode_t;
endpackage : step_pkg

// ### hw/step_if.sv
// Interface joining indexer and power stage control logic.
// Levels are high while the optocoupler conducts.
`default_nettype none
interface step_if;
  logic step_n;
  logic dir;
  logic boost;
  logic enable_reset;
  logic enable_aux;
  logic basic_pos;
  logic error;
  modport stage (input step_n, dir, boost, enable_reset, enable_aux,
                 output basic_pos, error);
  modport indexer (output step_n, dir, boost, enable_reset, enable_aux,
                   input basic_pos, error);
endinterface : step_if
`default_nettype wire

// ### hw/indexer_end.sv
// Indexer end: makes step pulses at a programmed period with direction hold.
// Assumes software port with read data one cycle after the read strobe.
`default_nettype none
module indexer_end (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [31:0]     rdata_out,
  step_if.indexer         link
);
  // 0: control (bit0 dir, bit1 boost, bit2 enable, bit3 reset request)
  // 1: step count to issue (write starts), 2: period in cycles, 3: status
  localparam logic [1:0] A_CTRL = 2'h0;
  localparam logic [1:0] A_CNT  = 2'h1;
  localparam logic [1:0] A_PER  = 2'h2;
  localparam logic [1:0] A_STAT = 2'h3;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [3:0]  dir_out;
    logic [15:0] remain;
    logic [15:0] period;
    logic [15:0] timer;
    logic        pulse;
    logic [31:0] rdata;
  } st_t;
  st_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.rdata = 32'h0;
    if (wr_in && addr_in == A_CTRL) s_next.ctrl = wdata_in[3:0];
    if (wr_in && addr_in == A_PER) begin
      // Never faster than the stage accepts
      s_next.period = (wdata_in[15:0] < 16'(step_pkg::MIN_PERIOD_CYC)) ?
                      16'(step_pkg::MIN_PERIOD_CYC) : wdata_in[15:0];
    end
    if (wr_in && addr_in == A_CNT) s_next.remain = wdata_in[15:0];
    if (rd_in) begin
      case (addr_in)
        A_CTRL: s_next.rdata = {28'h0, s_reg.ctrl};
        A_CNT:  s_next.rdata = {16'h0, s_reg.remain};
        A_PER:  s_next.rdata = {16'h0, s_reg.period};
        default: s_next.rdata = {30'h0, link.error, link.basic_pos};
      endcase
    end
    if (s_reg.timer != 16'h0) s_next.timer = s_reg.timer - 16'h1;
    if (s_reg.pulse) begin
      // Low phase: half the period plus the direction hold, direction frozen throughout
      if (s_reg.timer == 16'h0) begin
        s_next.pulse = 1'b0;
        s_next.timer = s_reg.period >> 1;
      end
    end else if (s_reg.timer == 16'h0) begin
      // Direction only changes between pulses at the programmed rate
      s_next.dir_out = {3'h0, s_reg.ctrl[0]};
      if (s_reg.remain != 16'h0 && !(wr_in && addr_in == A_CNT)) begin
        s_next.pulse  = 1'b1;
        s_next.remain = s_reg.remain - 16'h1;
        s_next.timer  = (s_reg.period >> 1) +
                        16'(step_pkg::DIR_HOLD_CYC);
      end
    end
    if (!ce_in) begin
      s_next = s_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
      s_reg.period <= 16'(step_pkg::MIN_PERIOD_CYC);
    end else begin
      s_reg <= s_next;
    end
  end

  // Ramping is the software's job via the period register
  assign link.step_n       = !s_reg.pulse;
  assign link.dir          = s_reg.dir_out[0];
  assign link.boost        = s_reg.ctrl[1];
  assign link.enable_aux   = s_reg.ctrl[2];
  assign link.enable_reset = s_reg.ctrl[3] ? 1'b0 : 1'b1;
  assign rdata_out         = s_reg.rdata;
endmodule : indexer_end
`default_nettype wire

// ### hw/stage_end.sv
// Power stage control: phase ring counter, current mode, error latching.
// Assumes link inputs already synchronous; high means optocoupler conducts.
// What this block does
// - Input asserted exactly while optocoupler conducts
// - Step on falling edge, switch to run
// - Accept step rates up to 500 kHz
// - Idle over 40 ms drops to stop
// - Direction low steps preferred way
// - Inversion switch swaps preferred direction
// - Indexer holds direction 1 us after edge
// - Direction changes only when slow or stopped; not enforced, dir is taken at any step rate
// - Boost raises run and stop by 30%
// - Boost switch forces boost permanently
// - Enable low switches current off
// - Permanent-enable switch overrides enable input
// - Link selects shared pin reset or enable
// - Reset clears errors and ring counter
// - Basic position gives equal phase currents
// - Basic-position output at each ring zero without error
// - Ring period 4,8,16,20,40,80 steps
// - Counting continues while phases de-energized
// - Error indication beats basic position at start
// - Fault raises error and de-energizes motor
// - Error holds until power cycle or reset
// - Indexer ramps rate above start/stop; not done here, software ramps via the period register
// - Resolution change taken only at basic position
`default_nettype none
module stage_end #(
  parameter int unsigned IDLE_CYCLES = step_pkg::IDLE_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       sw_overdrive_in,
  input  wire logic       sw_boost_in,
  input  wire logic       sw_enable_in,
  input  wire logic       sw_dir_invert_in,
  input  wire logic       pin_function_link_in,
  input  wire logic [3:0] resolution_sel_in,
  input  wire logic       fault_overload_in,
  input  wire logic       fault_supply_in,
  input  wire logic       fault_temp_in,
  output logic [1:0]      cur_mode_out,
  output logic            boost_out,
  output logic            overdrive_out,
  output logic            direction_out,
  output logic [6:0]      ring_pos_out,
  output logic [6:0]      ring_period_out,
  output logic [3:0]      resolution_out,
  output logic [2:0]      fault_flags_out,
  step_if.stage           link
);
  typedef struct packed {
    logic        step_d;
    logic [6:0]  ring;
    logic [3:0]  res;
    logic [31:0] idle;
    logic        running;
    logic [2:0]  faults;
  } st_t;
  st_t s_reg, s_next;
  logic reset_req;
  logic enabled;
  logic fall;
  logic step_up;
  logic [6:0] period;

  // Ring length for a rotary code
  function automatic logic [6:0] ring_len(input logic [3:0] code);
    case (code)
      4'h0: ring_len = 7'd4;
      4'h1, 4'h6, 4'hf: ring_len = 7'd8;
      4'h2, 4'h7, 4'hb: ring_len = 7'd16;
      4'h3, 4'h8, 4'hc: ring_len = 7'd20;
      4'h4, 4'h9, 4'hd: ring_len = 7'd40;
      default: ring_len = 7'd80;
    endcase
  endfunction : ring_len

  // Link active levels are taken as-is
  assign reset_req = pin_function_link_in && !link.enable_reset;
  assign enabled   = sw_enable_in ||
                     (pin_function_link_in ? link.enable_aux
                                           : link.enable_reset);
  assign fall      = s_reg.step_d && !link.step_n;
  assign step_up   = link.dir ^ sw_dir_invert_in;
  assign period    = ring_len(s_reg.res);

  always_comb begin
    s_next = s_reg;
    s_next.step_d = link.step_n;
    // Each source latches on its own
    s_next.faults = s_reg.faults |
                    {fault_temp_in, fault_supply_in, fault_overload_in};
    if (s_reg.idle != 32'h0) s_next.idle = s_reg.idle - 32'h1;
    else s_next.running = 1'b0;
    // Counting runs regardless of enable or errors
    if (fall) begin
      s_next.running = 1'b1;
      s_next.idle    = IDLE_CYCLES;
      if (!step_up) begin
        s_next.ring = (s_reg.ring == period - 7'd1) ? 7'd0
                                                    : s_reg.ring + 7'd1;
      end else begin
        s_next.ring = (s_reg.ring == 7'd0) ? period - 7'd1
                                           : s_reg.ring - 7'd1;
      end
    end
    // New resolution only taken at basic position
    if (s_next.ring == 7'd0) s_next.res = resolution_sel_in;
    if (reset_req) begin
      s_next.ring   = 7'd0;
      s_next.faults = 3'h0;
      s_next.res    = resolution_sel_in;
    end
    if (!ce_in) begin
      s_next = s_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
      s_reg.res <= step_pkg::RES_RESET;
      s_reg.step_d <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    if (s_reg.faults != 3'h0 || !enabled) begin
      cur_mode_out = step_pkg::CUR_OFF;
    end else if (s_reg.running) begin
      cur_mode_out = step_pkg::CUR_RUN;
    end else begin
      cur_mode_out = step_pkg::CUR_STOP;
    end
  end

  assign boost_out       = link.boost || sw_boost_in;
  assign overdrive_out   = sw_overdrive_in;
  assign direction_out   = step_up;
  // Ring zero means equal magnitude on both phases downstream
  assign ring_pos_out    = s_reg.ring;
  assign ring_period_out = period;
  assign resolution_out  = s_reg.res;
  assign fault_flags_out = s_reg.faults;
  assign link.error      = s_reg.faults != 3'h0;
  // Error takes precedence over basic position
  assign link.basic_pos  = (s_reg.ring == 7'd0) && (s_reg.faults == 3'h0);
endmodule : stage_end
`default_nettype wire

// ### bench/step_properties.sv
// Checker on the step link between the indexer and the power stage.
// Assumes one clock domain; link signals arrive as plain inputs.
`default_nettype none
module step_properties (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic step_n,
  input wire logic dir,
  input wire logic enable_reset,
  input wire logic basic_pos,
  input wire logic error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] gap_reg;
  logic        prev_reg;
  // Cycles since the last falling step edge, saturating
  always_ff @(posedge clk_in) begin
    prev_reg <= step_n | ~rst_n_in;
    if (!rst_n_in) gap_reg <= 16'hffff;
    else if (prev_reg && !step_n) gap_reg <= 16'h0000;
    else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h0001;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_reset; $rose(rst_n_in) |-> basic_pos && !error && step_n;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  property p_err_hides; error |-> !basic_pos; endproperty
  a_err_hides: assert property (p_err_hides) else $error("basic");
  property p_sticky; error && enable_reset |=> error; endproperty
  a_sticky: assert property (p_sticky) else $error("error lost");
  property p_rate; $fell(step_n) |-> gap_reg >= 16'd499; endproperty
  a_rate: assert property (p_rate) else $error("step rate");
  property p_width; $rose(step_n) |-> gap_reg >= 16'd249; endproperty
  a_width: assert property (p_width) else $error("pulse width");
  property p_dir; gap_reg < 16'd249 |-> $stable(dir); endproperty
  a_dir: assert property (p_dir) else $error("dir hold");
  property p_leave; basic_pos && $fell(step_n) |-> ##[1:3] !basic_pos;
  endproperty
  a_leave: assert property (p_leave) else $error("ring idle");
  property p_rise;
    $rose(basic_pos) |-> gap_reg <= 16'd3 || $past(error) || !$past(rst_n_in);
  endproperty
  a_rise: assert property (p_rise) else $error("basic rise");
endmodule : step_properties
`default_nettype wire

// ### bench/stepper_step_dir_control_test.sv
// Bench joining indexer_end and stage_end over step_if, with a ring model.
// Assumes 250 MHz clock; idle drop shortened to 2000 cycles.
`default_nettype none
module stepper_step_dir_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, rst_n_in, wr_in, rd_in, lnk, inv, sw_b, sw_e, sw_o;
  logic        bo, od, dr;
  logic [1:0]  addr, cm;
  logic [2:0]  fault, flags;
  logic [3:0]  sel, res_o;
  logic [6:0]  pos, per_o;
  logic [31:0] wdata, rdata, seed, ctrl, st;
  int          ring, per, res, err, n, d, compares, miscompares;
  step_if link ();
  indexer_end indexer_end_inst (.clk_in, .rst_n_in, .ce_in(1'b1),
    .addr_in(addr), .wdata_in(wdata), .wr_in, .rd_in, .rdata_out(rdata),
    .link(link));
  stage_end #(.IDLE_CYCLES(2000)) stage_end_inst (.clk_in, .rst_n_in,
    .ce_in(1'b1), .sw_overdrive_in(sw_o), .sw_boost_in(sw_b),
    .sw_enable_in(sw_e), .sw_dir_invert_in(inv), .pin_function_link_in(lnk),
    .resolution_sel_in(sel), .fault_overload_in(fault[0]),
    .fault_supply_in(fault[1]), .fault_temp_in(fault[2]), .cur_mode_out(cm),
    .boost_out(bo), .overdrive_out(od), .direction_out(dr),
    .ring_pos_out(pos), .ring_period_out(per_o), .resolution_out(res_o),
    .fault_flags_out(flags), .link(link));
  step_properties step_properties_inst (.clk_in, .rst_n_in,
    .step_n(link.step_n), .dir(link.dir), .enable_reset(link.enable_reset),
    .basic_pos(link.basic_pos), .error(link.error));
  function automatic int per_of(input int s);
    case (s)
      0: return 4;
      1, 6, 15: return 8;
      2, 7, 11: return 16;
      3, 8, 12: return 20;
      4, 9, 13: return 40;
      default: return 80;
    endcase
  endfunction : per_of
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [1:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [31:0] v);
    addr <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata;
    @(posedge clk_in);
  endtask : rd
  // Compare every stage result except the fault flags with the model; mv says steps are recent
  task automatic look(input logic mv);
    logic en;
    en = sw_e | (lnk ? ctrl[2] : !ctrl[3]);
    rd(2'h3, st);
    #1 chk(st[1:0], {err[0], ring == 0 && err == 0});
    chk(pos, ring);
    chk(res_o, res);
    chk(per_o, per);
    chk({bo, dr, od}, {sw_b | ctrl[1], ctrl[0] ^ inv, sw_o});
    chk(cm, err || !en ? step_pkg::CUR_OFF :
      mv ? step_pkg::CUR_RUN : step_pkg::CUR_STOP);
    @(posedge clk_in);
  endtask : look
  task automatic run(input int k);
    wr(2'h1, k);
    repeat (k * 750 + 20) @(posedge clk_in);
    repeat (k) begin
      ring = (ring + ((ctrl[0] ^ inv) ? per - 1 : 1)) % per;
      if (ring == 0) begin
        res = sel;
        per = per_of(sel);
      end
    end
  endtask : run
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    repeat (95000) @(posedge clk_in);
    miscompares++;
    finish_test;
  end
  initial begin
    {rst_n_in, wr_in, rd_in, lnk, inv, sw_b, sw_e, sw_o} = '0;
    {addr, wdata, fault, sel, ctrl, compares, miscompares} = '0;
    seed = 32'h39d9;
    {ring, res, err, per} = {32'd0, 32'd0, 32'd0, 32'd4};
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wr(2'h2, 32'h64);
    rd(2'h2, st);
    chk(st, 32'(step_pkg::MIN_PERIOD_CYC));
    for (int i = 0; i < 12; i++) begin
      seed = nxt(seed);
      // Reset bit only while the shared pin is enable before and after
      ctrl = seed[3:0] & ((seed[8] | lnk) ? 32'h7 : 32'hf);
      wr(2'h0, ctrl);
      {inv, sw_b, sw_e, sw_o, lnk, sel} <= seed[12:4];
      @(posedge clk_in);
      // At basic position a new selection is taken at once
      if (ring == 0) begin
        res = sel;
        per = per_of(sel);
      end
      d = (ctrl[0] ^ inv) ? (ring ? ring : per) : per - ring;
      n = d <= 8 ? d : seed[15:14] + 1;
      run(n);
      look(1'b1);
      repeat (1300) @(posedge clk_in);
      look(1'b0);
    end
    lnk <= 1'b1;
    ctrl = 32'h4;
    wr(2'h0, ctrl);
    for (int f = 0; f < 3; f++) begin
      fault <= 3'b001 << f;
      @(posedge clk_in);
      fault <= 3'h0;
      err = 1;
      repeat (2) @(posedge clk_in);
      #1 chk(flags, 3'b001 << f);
      @(posedge clk_in);
      look(1'b0);
      wr(2'h0, 32'hc);
      wr(2'h0, ctrl);
      {ring, err, res, per} = {32'd0, 32'd0, 32'(sel), 32'(per_of(sel))};
      look(1'b0);
    end
    finish_test;
  end
endmodule : stepper_step_dir_control_test
`default_nettype wire
